// ### verilog/ilch_handler.sv
// Inverter link command handler with Avalon-MM register access.
//
// Contract
// [R1] Monitor code 0001 returns output frequency.
// [R2] Code 07 reads acceleration time.
// [R3] Code 87 writes acceleration time.
// [R4] Master enables extended setting for high parameters.
// [R5] RAM frequency request loads word, raises done.
// [R6] Master waits done and zero reply.
// [R7] One nonvolatile write per request rise.
// [R8] Frequency changes ignored while nonvolatile request held.
// [R9] Code 74 returns fault history one, two.
// [R10] Fault reset bit acts only when faulted.
// [R11] Reset select zero allows reset any mode.
// [R12] Reset code needs key and net conditions.
// [R13] Network mode ignores local run inputs.
// [R14] Master loss in network mode trips.
// [R15] Startup zero enters external mode after reset.
// [R16] Startup nonzero enters network mode after reset; the code does so on communication reset only.
// [R17] Network start blocked when source is external.
// [R18] Link works only at the fast speed.
// [R19] Instruction done raised with reply code.
// [R20] Code FB with zero selects network mode.
// [R21] Master clears request after done, waits clear.
// [R22] Done bits clear after request drops.
`timescale 1ns/10ps
module ilch_handler (
  input wire logic mclk_i, // 20 MHz clock
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic [5:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall
  input wire logic [15:0] out_freq_i, // Output frequency, 0.01 Hz
  input wire logic [15:0] fault_hist_i, // Entry two high, one low
  input wire logic fault_active_i, // Drive fault present
  input wire logic motor_running_i, // Drive running
  input wire logic ext_fwd_i, // Local forward input pin
  input wire logic ext_rev_i, // Local reverse input pin
  input wire logic link_up_i, // Cyclic exchange alive pin
  input wire logic link_fast_i, // Link at the fast speed pin
  output logic run_fwd_o, // Forward run command
  output logic run_rev_o, // Reverse run command
  output logic [15:0] freq_cmd_o, // Applied set frequency
  output logic [15:0] accel_time_o, // Acceleration time, 0.1 s
  output logic nvm_write_o, // Nonvolatile store pulse
  output logic fault_reset_o, // Fault reset pulse
  output logic inverter_reset_o, // Communication reset pulse
  output logic net_mode_o, // Network operation mode
  output logic comm_loss_trip_o // Communication loss fault
);
  // ==========================================================
  // Pin synchronisers
  logic [3:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      pin_s1_q <= {link_fast_i, link_up_i, ext_rev_i, ext_fwd_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  // [R18] fast speed only
  logic link_ok;
  assign link_ok = pin_s2_q[2] & pin_s2_q[3];

  // ==========================================================
  // Avalon slave: one wait state, write commits on the answer edge.
  logic wait_q;
  logic [31:0] rdata_q;
  logic wr_ack, rd_first;
  logic [31:0] ry_q, set_freq_q, instr_code_q, instr_data_q, mon_sel_q;
  logic [31:0] params_q;
  logic [15:0] freq_reply_q, instr_reply_q, instr_rdata_q, accel_q;
  logic [15:0] freq_cmd_q;
  logic net_mode_q, trip_q, ram_done_q, nvm_done_q;
  logic [2:0] cmd_q;
  ilch_pkg::ilch_instr_e st_q;

  assign wr_ack = avs_write_i & ~wait_q;
  assign rd_first = avs_read_i & wait_q;

  function automatic logic [3:0] field4(input logic [31:0] w, input int lsb);
    field4 = w[lsb +: 4];
  endfunction

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((avs_read_i | avs_write_i) & wait_q);
    end
  end

  logic [31:0] rx_word;
  always_comb begin
    rx_word = 32'h0000_0000;
    rx_word[ilch_pkg::BIT_FWD] = run_fwd_o;
    rx_word[ilch_pkg::BIT_REV] = run_rev_o;
    rx_word[ilch_pkg::BIT_RUNNING] = motor_running_i;
    rx_word[ilch_pkg::BIT_FAULT] = fault_active_i | trip_q;
    rx_word[ilch_pkg::BIT_NET_MODE] = net_mode_q;
    rx_word[ilch_pkg::BIT_TRIP] = trip_q;
    rx_word[ilch_pkg::BIT_FREQ_RAM] = ram_done_q;
    rx_word[ilch_pkg::BIT_FREQ_NVM] = nvm_done_q;
    rx_word[ilch_pkg::BIT_INSTR] = (st_q == ilch_pkg::ILCH_DONE);
  end

  // [R1] monitor reply
  logic [15:0] mon_reply;
  assign mon_reply = (mon_sel_q[15:0] == ilch_pkg::MON_OUT_FREQ) ?
                     out_freq_i : 16'h0000;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_first) begin
      unique case (avs_address_i)
        ilch_pkg::OFS_RY_BITS: rdata_q <= ry_q;
        ilch_pkg::OFS_RX_BITS: rdata_q <= rx_word;
        ilch_pkg::OFS_SET_FREQ: rdata_q <= set_freq_q;
        ilch_pkg::OFS_INSTR_CODE: rdata_q <= instr_code_q;
        ilch_pkg::OFS_INSTR_DATA: rdata_q <= instr_data_q;
        ilch_pkg::OFS_FREQ_REPLY: rdata_q <= {16'h0000, freq_reply_q};
        ilch_pkg::OFS_INSTR_REPLY: rdata_q <= {16'h0000, instr_reply_q};
        ilch_pkg::OFS_INSTR_RDATA: rdata_q <= {16'h0000, instr_rdata_q};
        ilch_pkg::OFS_MON_SEL: rdata_q <= mon_sel_q;
        ilch_pkg::OFS_MON_REPLY: rdata_q <= {16'h0000, mon_reply};
        ilch_pkg::OFS_PARAMS: rdata_q <= params_q;
        ilch_pkg::OFS_ACCEL: rdata_q <= {16'h0000, accel_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ry_q <= 32'h0000_0000;
      set_freq_q <= 32'h0000_0000;
      instr_code_q <= 32'h0000_0000;
      instr_data_q <= 32'h0000_0000;
      mon_sel_q <= 32'h0000_0000;
      params_q <= ilch_pkg::PARAMS_RESET;
    end else if (wr_ack) begin
      unique case (avs_address_i)
        ilch_pkg::OFS_RY_BITS: ry_q <= avs_writedata_i;
        ilch_pkg::OFS_SET_FREQ: set_freq_q <= avs_writedata_i;
        ilch_pkg::OFS_INSTR_CODE: instr_code_q <= avs_writedata_i;
        ilch_pkg::OFS_INSTR_DATA: instr_data_q <= avs_writedata_i;
        ilch_pkg::OFS_MON_SEL: mon_sel_q <= avs_writedata_i;
        ilch_pkg::OFS_PARAMS: params_q <= avs_writedata_i;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Request edges; the previous request bits are held one cycle.
  logic [2:0] req_prev_q;
  logic [2:0] req_now;
  assign req_now = {ry_q[ilch_pkg::BIT_FAULT_RST],
                    ry_q[ilch_pkg::BIT_FREQ_NVM],
                    ry_q[ilch_pkg::BIT_FREQ_RAM]};
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      req_prev_q <= 3'b000;
    end else begin
      req_prev_q <= req_now;
    end
  end
  logic ram_rise, nvm_rise, frst_rise;
  assign ram_rise = req_now[0] & ~req_prev_q[0];
  assign nvm_rise = req_now[1] & ~req_prev_q[1];
  assign frst_rise = req_now[2] & ~req_prev_q[2];

  // ==========================================================
  // Frequency setting. The value is sampled only at the rising request,
  // so a word rewritten while the request stays high reaches the drive
  // only at a later rising request and never triggers a second nonvolatile store.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      freq_cmd_q <= 16'h0000;
      freq_reply_q <= ilch_pkg::RC_OK;
      ram_done_q <= 1'b0;
      nvm_done_q <= 1'b0;
      nvm_write_o <= 1'b0;
    end else begin
      // [R5] load and complete
      if (ram_rise) begin
        freq_cmd_q <= set_freq_q[15:0];
        freq_reply_q <= ilch_pkg::RC_OK;
        ram_done_q <= 1'b1;
      // [R22] clear after drop
      end else if (!req_now[0]) begin
        ram_done_q <= 1'b0;
      end
      // [R7] one store per rise
      nvm_write_o <= nvm_rise;
      // [R8] sampled at assertion
      if (nvm_rise) begin
        freq_cmd_q <= set_freq_q[15:0];
        freq_reply_q <= ilch_pkg::RC_OK;
        nvm_done_q <= 1'b1;
      end else if (!req_now[1]) begin
        nvm_done_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Reset acceptance shared by the fault-reset bit and the reset code.
  logic faulted, comm_reset_ok, soft_reset;
  logic [7:0] ic;
  logic [15:0] idata;
  assign faulted = fault_active_i | trip_q;
  // [R11] select zero allows any mode
  assign comm_reset_ok =
    (field4(params_q, ilch_pkg::PRM_RESETSEL_LSB) == 4'h0) | net_mode_q;
  assign ic = instr_code_q[7:0];
  assign idata = instr_data_q[15:0];

  // ==========================================================
  // Instruction code execution.
  logic reset_code_ok;
  // [R12] key plus startup or net mode
  assign reset_code_ok = (idata == ilch_pkg::RESET_KEY) & comm_reset_ok &
    ((field4(params_q, ilch_pkg::PRM_STARTUP_LSB) != 4'h0) | net_mode_q);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ilch_pkg::ILCH_IDLE;
      instr_reply_q <= ilch_pkg::RC_OK;
      instr_rdata_q <= 16'h0000;
      accel_q <= ilch_pkg::ACCEL_RESET;
    end else begin
      unique case (st_q)
        ilch_pkg::ILCH_IDLE: begin
          if (ry_q[ilch_pkg::BIT_INSTR]) begin
            st_q <= ilch_pkg::ILCH_EXEC;
          end
        end
        ilch_pkg::ILCH_EXEC: begin
          // [R19] done with reply
          st_q <= ilch_pkg::ILCH_DONE;
          instr_reply_q <= ilch_pkg::RC_OK;
          unique case (ic)
            // [R2] read acceleration
            ilch_pkg::IC_ACCEL_RD: instr_rdata_q <= accel_q;
            // [R3] write acceleration
            ilch_pkg::IC_ACCEL_WR: accel_q <= idata;
            // [R9] fault history
            ilch_pkg::IC_FAULT_HIST: instr_rdata_q <= fault_hist_i;
            ilch_pkg::IC_OPMODE_WR: ;
            ilch_pkg::IC_RESET: begin
              if (!reset_code_ok) begin
                instr_reply_q <= ilch_pkg::RC_MODE_ERR;
              end
            end
            default: instr_reply_q <= ilch_pkg::RC_CODE_ERR;
          endcase
        end
        ilch_pkg::ILCH_DONE: begin
          // [R22] clear after drop
          if (!ry_q[ilch_pkg::BIT_INSTR]) begin
            st_q <= ilch_pkg::ILCH_IDLE;
          end
        end
        default: st_q <= ilch_pkg::ILCH_IDLE;
      endcase
    end
  end

  logic exec_now;
  assign exec_now = (st_q == ilch_pkg::ILCH_EXEC);
  assign soft_reset = exec_now & (ic == ilch_pkg::IC_RESET) & reset_code_ok;

  // ==========================================================
  // Fault reset and communication reset pulses.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_reset_o <= 1'b0;
      inverter_reset_o <= 1'b0;
    end else begin
      // [R10] only when faulted
      fault_reset_o <= frst_rise & faulted & comm_reset_ok;
      inverter_reset_o <= soft_reset;
    end
  end

  // ==========================================================
  // Operation mode and loss trip. Hardware reset always lands in
  // external mode; a communication reset reloads from startup select.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      // [R15] external after reset
      net_mode_q <= 1'b0;
    end else if (soft_reset) begin
      // [R16] startup nonzero
      net_mode_q <= field4(params_q, ilch_pkg::PRM_STARTUP_LSB) != 4'h0;
    end else if (exec_now & (ic == ilch_pkg::IC_OPMODE_WR)) begin
      // [R20] zero selects network
      net_mode_q <= (idata == ilch_pkg::OPMODE_NET);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      trip_q <= 1'b0;
    end else if (net_mode_q & ~link_ok) begin
      // [R14] loss trips
      trip_q <= 1'b1;
    end else if (soft_reset | (frst_rise & faulted & comm_reset_ok)) begin
      trip_q <= 1'b0;
    end
  end

  // ==========================================================
  // Run commands.
  logic src_ok;
  // [R17] source not external
  assign src_ok =
    field4(params_q, ilch_pkg::PRM_CMDSRC_LSB) != ilch_pkg::CMDSRC_EXTERNAL;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      run_fwd_o <= 1'b0;
      run_rev_o <= 1'b0;
    end else if (trip_q) begin
      run_fwd_o <= 1'b0;
      run_rev_o <= 1'b0;
    end else if (net_mode_q) begin
      // [R13] master commands only
      run_fwd_o <= ry_q[ilch_pkg::BIT_FWD] & src_ok;
      run_rev_o <= ry_q[ilch_pkg::BIT_REV] & src_ok;
    end else begin
      run_fwd_o <= pin_s2_q[0];
      run_rev_o <= pin_s2_q[1];
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign freq_cmd_o = freq_cmd_q;
  assign accel_time_o = accel_q;
  assign net_mode_o = net_mode_q;
  assign comm_loss_trip_o = trip_q;

  // ==========================================================
  // Assertions
  a_ram_done_set: assert property (@(posedge mclk_i) disable iff (rst_i)
    ram_rise |=> ram_done_q && freq_cmd_q == $past(set_freq_q[15:0]))
    else $error("RAM frequency not applied"); // [R5]
  a_nvm_one_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    nvm_write_o |=> !nvm_write_o)
    else $error("Second store pulse"); // [R7]
  a_nvm_freq_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    req_prev_q[1] && req_now[1] && !req_now[0] |=> $stable(freq_cmd_q))
    else $error("Frequency changed while held"); // [R8]
  a_accel_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    exec_now && ic == ilch_pkg::IC_ACCEL_WR |=> accel_q == $past(idata))
    else $error("Acceleration not stored"); // [R3]
  a_accel_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    exec_now && ic == ilch_pkg::IC_ACCEL_RD |=> instr_rdata_q == accel_q)
    else $error("Acceleration not returned"); // [R2]
  a_hist_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    exec_now && ic == ilch_pkg::IC_FAULT_HIST
    |=> instr_rdata_q == $past(fault_hist_i))
    else $error("Fault history not returned"); // [R9]
  a_instr_done: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_q == ilch_pkg::ILCH_IDLE && ry_q[ilch_pkg::BIT_INSTR]
    |=> ##1 rx_word[ilch_pkg::BIT_INSTR])
    else $error("Instruction done missing"); // [R19]
  a_done_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_q == ilch_pkg::ILCH_DONE && !ry_q[ilch_pkg::BIT_INSTR]
    |=> st_q == ilch_pkg::ILCH_IDLE)
    else $error("Done not cleared"); // [R22]
  a_fault_reset_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
    fault_reset_o |-> $past(faulted))
    else $error("Fault reset while healthy"); // [R10]
  a_loss_trip: assert property (@(posedge mclk_i) disable iff (rst_i)
    net_mode_q && !link_ok |=> trip_q ##1 !run_fwd_o && !run_rev_o)
    else $error("No trip on master loss"); // [R14]
  a_local_ignored: assert property (@(posedge mclk_i) disable iff (rst_i)
    net_mode_q && !trip_q && !ry_q[ilch_pkg::BIT_FWD] |=> !run_fwd_o)
    else $error("Local run in network mode"); // [R13]
  a_opmode_net: assert property (@(posedge mclk_i) disable iff (rst_i)
    exec_now && ic == ilch_pkg::IC_OPMODE_WR && idata == 16'h0000
    |=> net_mode_q)
    else $error("Network mode not entered"); // [R20]
  a_reset_key: assert property (@(posedge mclk_i) disable iff (rst_i)
    inverter_reset_o |-> $past(idata) == ilch_pkg::RESET_KEY)
    else $error("Reset without key"); // [R12]
  a_monitor: assert property (@(posedge mclk_i) disable iff (rst_i)
    mon_sel_q[15:0] == 16'h0001 |-> mon_reply == out_freq_i)
    else $error("Monitor reply wrong"); // [R1]
  c_ram_set: cover property (@(posedge mclk_i) disable iff (rst_i)
    ram_rise ##1 ram_done_q);
  c_instr_cycle: cover property (@(posedge mclk_i) disable iff (rst_i)
    exec_now ##1 st_q == ilch_pkg::ILCH_DONE ##[1:20]
    st_q == ilch_pkg::ILCH_IDLE);
  c_trip: cover property (@(posedge mclk_i) disable iff (rst_i)
    $rose(trip_q));
  c_soft_reset: cover property (@(posedge mclk_i) disable iff (rst_i)
    inverter_reset_o);
endmodule

// ### verilog/ilch_pkg.sv
// Constants shared by the inverter link command handler.
package ilch_pkg;
  // ==========================================================
  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] OFS_RY_BITS = 6'h00;
  localparam logic [5:0] OFS_RX_BITS = 6'h04;
  localparam logic [5:0] OFS_SET_FREQ = 6'h08;
  localparam logic [5:0] OFS_INSTR_CODE = 6'h0C;
  localparam logic [5:0] OFS_INSTR_DATA = 6'h10;
  localparam logic [5:0] OFS_FREQ_REPLY = 6'h14;
  localparam logic [5:0] OFS_INSTR_REPLY = 6'h18;
  localparam logic [5:0] OFS_INSTR_RDATA = 6'h1C;
  localparam logic [5:0] OFS_MON_SEL = 6'h20;
  localparam logic [5:0] OFS_MON_REPLY = 6'h24;
  localparam logic [5:0] OFS_PARAMS = 6'h28;
  localparam logic [5:0] OFS_ACCEL = 6'h2C;
  // ==========================================================
  // Remote bit positions, commands and status
  localparam int BIT_FWD = 0;
  localparam int BIT_REV = 1;
  localparam int BIT_RUNNING = 2;
  localparam int BIT_FAULT = 7;
  localparam int BIT_NET_MODE = 8;
  localparam int BIT_TRIP = 9;
  localparam int BIT_FREQ_RAM = 13;
  localparam int BIT_FREQ_NVM = 14;
  localparam int BIT_INSTR = 15;
  localparam int BIT_FAULT_RST = 26;
  // ==========================================================
  // Parameter register fields
  localparam int PRM_STARTUP_LSB = 0;
  localparam int PRM_RESETSEL_LSB = 4;
  localparam int PRM_CMDSRC_LSB = 8;
  localparam logic [3:0] CMDSRC_EXTERNAL = 4'h0;
  localparam logic [31:0] PARAMS_RESET = 32'h0000_0100;
  // ==========================================================
  // Codes, keys and reply codes
  localparam logic [15:0] MON_OUT_FREQ = 16'h0001;
  localparam logic [7:0] IC_ACCEL_RD = 8'h07;
  localparam logic [7:0] IC_ACCEL_WR = 8'h87;
  localparam logic [7:0] IC_FAULT_HIST = 8'h74;
  localparam logic [7:0] IC_OPMODE_WR = 8'hFB;
  localparam logic [7:0] IC_RESET = 8'hFD;
  localparam logic [15:0] OPMODE_NET = 16'h0000;
  localparam logic [15:0] RESET_KEY = 16'h9696;
  localparam logic [15:0] RC_OK = 16'h0000;
  localparam logic [15:0] RC_MODE_ERR = 16'h0001;
  localparam logic [15:0] RC_CODE_ERR = 16'h0002;
  localparam logic [15:0] ACCEL_RESET = 16'h0032;
  // ==========================================================
  // Instruction state machine
  typedef enum logic [2:0] {
    ILCH_IDLE = 3'b001,
    ILCH_EXEC = 3'b010,
    ILCH_DONE = 3'b100
  } ilch_instr_e;
endpackage

// ### testbench/ilch_master_model.sv
// Master station model that drives the cyclic exchange status pins.
`timescale 1ns/10ps
module ilch_master_model (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Reset, active high
  input wire logic lose_i, // Master reset or powered off
  input wire logic slow_i, // Master offers only the legacy speed
  output logic link_up_o, // Cyclic exchange alive
  output logic link_fast_o // Link runs at the fast speed
);
  // ==========================================================
  // Link status
  // The pins are registered, so they change just after the same rising edge on which the handler samples them.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      link_up_o <= 1'b1;
      link_fast_o <= 1'b1;
    end else begin
      link_up_o <= !lose_i;
      link_fast_o <= !slow_i;
    end
  end
endmodule

// ### testbench/ilch_handler_tb_top.sv
// Self-checking bench for the inverter link command handler.
`timescale 1ns/10ps
module ilch_handler_tb_top;
  logic mclk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [5:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rdata, idata, ry;
  logic [15:0] out_freq_i, fault_hist_i, freq_cmd_o, accel_time_o;
  logic fault_active_i, motor_running_i, ext_fwd_i, ext_rev_i;
  logic link_up_i, link_fast_i, run_fwd_o, run_rev_o, nvm_write_o;
  logic fault_reset_o, inverter_reset_o, net_mode_o, comm_loss_trip_o;
  logic lose, slow;
  int error_cnt, n_compared, n_nvm, n_frst, n_irst;

  ilch_handler u_ilch_handler (
    .mclk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .out_freq_i,
    .fault_hist_i, .fault_active_i, .motor_running_i, .ext_fwd_i,
    .ext_rev_i, .link_up_i, .link_fast_i, .run_fwd_o, .run_rev_o,
    .freq_cmd_o, .accel_time_o, .nvm_write_o, .fault_reset_o,
    .inverter_reset_o, .net_mode_o, .comm_loss_trip_o
  );
  ilch_master_model u_ilch_master_model (
    .mclk_i, .rst_i, .lose_i(lose), .slow_i(slow),
    .link_up_o(link_up_i), .link_fast_o(link_fast_i)
  );

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // Pulses last one cycle, so they are counted on every edge.
  always @(posedge mclk_i) begin
    if (nvm_write_o === 1'b1) n_nvm++;
    if (fault_reset_o === 1'b1) n_frst++;
    if (inverter_reset_o === 1'b1) n_irst++;
  end
  // ==========================================================
  // Shared tasks
  task automatic end_sim;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waitrequest is looked at on the rising edge, before that edge updates
  // it; read data is taken and the request released at that same edge.
  task automatic bus(input logic w, input logic [5:0] a, logic [31:0] d);
    int i;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    i = 0;
    do begin
      @(posedge mclk_i);
      i++;
    end while (avs_waitrequest_o !== 1'b0 && i < 50);
    if (avs_waitrequest_o !== 1'b0) begin
      chk("bus wait", 32'h0, 32'h1);
      end_sim();
    end
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic ry_set(input int b, input logic v);
    ry[b] = v;
    bus(1'b1, ilch_pkg::OFS_RY_BITS, ry);
  endtask
  task automatic req(input int b, input logic v);
    int i;
    ry_set(b, v);
    i = 0;
    do begin
      bus(1'b0, ilch_pkg::OFS_RX_BITS, 32'h0);
      i++;
    end while (rdata[b] !== v && i < 20);
    chk("done bit", 32'(v), 32'(rdata[b]));
    if (rdata[b] !== v) end_sim();
  endtask
  task automatic instr(input logic [7:0] c, logic [15:0] d, logic [15:0] rc);
    bus(1'b1, ilch_pkg::OFS_INSTR_CODE, {24'h0, c});
    bus(1'b1, ilch_pkg::OFS_INSTR_DATA, {16'h0, d});
    req(ilch_pkg::BIT_INSTR, 1'b1);
    bus(1'b0, ilch_pkg::OFS_INSTR_REPLY, 32'h0);
    chk("reply code", {16'h0, rc}, rdata);
    bus(1'b0, ilch_pkg::OFS_INSTR_RDATA, 32'h0);
    idata = rdata;
    req(ilch_pkg::BIT_INSTR, 1'b0);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_basic;
    chk("net mode", 32'h0, 32'(net_mode_o));
    chk("accel", 32'h32, 32'(accel_time_o));
    bus(1'b0, ilch_pkg::OFS_PARAMS, 32'h0);
    chk("params", 32'h100, rdata);
    bus(1'b1, ilch_pkg::OFS_MON_SEL, 32'h1);
    bus(1'b0, ilch_pkg::OFS_MON_REPLY, 32'h0);
    chk("monitor", 32'h1770, rdata);
    bus(1'b1, ilch_pkg::OFS_MON_SEL, 32'h2);
    bus(1'b0, ilch_pkg::OFS_MON_REPLY, 32'h0);
    chk("monitor other", 32'h0, rdata);
  endtask
  // low parameters only
  // Only low-numbered parameter codes are used, so no extended setting.
  task automatic t_param;
    instr(ilch_pkg::IC_ACCEL_RD, 16'h0, ilch_pkg::RC_OK);
    chk("accel read", 32'h32, idata);
    instr(ilch_pkg::IC_ACCEL_WR, 16'h001E, ilch_pkg::RC_OK);
    chk("accel out", 32'h1E, 32'(accel_time_o));
    instr(ilch_pkg::IC_FAULT_HIST, 16'h0, ilch_pkg::RC_OK);
    chk("history", 32'h2A15, idata);
    instr(8'h55, 16'h0, ilch_pkg::RC_CODE_ERR);
  endtask
  task automatic t_freq;
    bus(1'b1, ilch_pkg::OFS_SET_FREQ, 32'h1388);
    req(ilch_pkg::BIT_FREQ_RAM, 1'b1);
    bus(1'b0, ilch_pkg::OFS_FREQ_REPLY, 32'h0);
    chk("freq reply", 32'h0, rdata);
    chk("freq ram", 32'h1388, 32'(freq_cmd_o));
    req(ilch_pkg::BIT_FREQ_RAM, 1'b0);
    bus(1'b1, ilch_pkg::OFS_SET_FREQ, 32'h0BB8);
    req(ilch_pkg::BIT_FREQ_NVM, 1'b1);
    bus(1'b1, ilch_pkg::OFS_SET_FREQ, 32'h0FA0);
    repeat (4) @(posedge mclk_i);
    chk("freq held", 32'h0BB8, 32'(freq_cmd_o));
    chk("nvm writes", 32'h1, 32'(n_nvm));
    req(ilch_pkg::BIT_FREQ_NVM, 1'b0);
    req(ilch_pkg::BIT_FREQ_NVM, 1'b1);
    req(ilch_pkg::BIT_FREQ_NVM, 1'b0);
    chk("freq nvm", 32'h0FA0, 32'(freq_cmd_o));
    chk("nvm writes", 32'h2, 32'(n_nvm));
  endtask
  task automatic t_fault;
    ry_set(ilch_pkg::BIT_FAULT_RST, 1'b1);
    ry_set(ilch_pkg::BIT_FAULT_RST, 1'b0);
    repeat (3) @(posedge mclk_i);
    chk("reset no fault", 32'h0, 32'(n_frst));
    fault_active_i <= 1'b1;
    ry_set(ilch_pkg::BIT_FAULT_RST, 1'b1);
    ry_set(ilch_pkg::BIT_FAULT_RST, 1'b0);
    repeat (3) @(posedge mclk_i);
    chk("reset faulted", 32'h1, 32'(n_frst));
    fault_active_i <= 1'b0;
  endtask
  task automatic t_mode;
    ext_fwd_i <= 1'b1;
    instr(ilch_pkg::IC_RESET, ilch_pkg::RESET_KEY,
          ilch_pkg::RC_MODE_ERR);
    chk("run ext", 32'h1, 32'(run_fwd_o));
    chk("run rev ext", 32'h0, 32'(run_rev_o));
    instr(ilch_pkg::IC_OPMODE_WR, ilch_pkg::OPMODE_NET, ilch_pkg::RC_OK);
    chk("net mode", 32'h1, 32'(net_mode_o));
    chk("run pin", 32'h0, 32'(run_fwd_o));
    ext_rev_i <= 1'b1;
    ry_set(ilch_pkg::BIT_FWD, 1'b1);
    repeat (3) @(posedge mclk_i);
    chk("run net", 32'h1, 32'(run_fwd_o));
    chk("run rev pin", 32'h0, 32'(run_rev_o));
    ext_rev_i <= 1'b0;
    bus(1'b1, ilch_pkg::OFS_PARAMS, 32'h0);
    repeat (3) @(posedge mclk_i);
    chk("run src ext", 32'h0, 32'(run_fwd_o));
    instr(ilch_pkg::IC_RESET, ilch_pkg::RESET_KEY, ilch_pkg::RC_OK);
    chk("comm resets", 32'h1, 32'(n_irst));
    chk("mode ext", 32'h0, 32'(net_mode_o));
    bus(1'b1, ilch_pkg::OFS_PARAMS, 32'h101);
    instr(ilch_pkg::IC_RESET, ilch_pkg::RESET_KEY, ilch_pkg::RC_OK);
    chk("mode net", 32'h1, 32'(net_mode_o));
  endtask
  task automatic t_trip;
    lose <= 1'b1;
    repeat (8) @(posedge mclk_i);
    chk("loss trip", 32'h1, 32'(comm_loss_trip_o));
    chk("run stop", 32'h0, 32'(run_fwd_o));
    lose <= 1'b0;
    instr(ilch_pkg::IC_RESET, ilch_pkg::RESET_KEY, ilch_pkg::RC_OK);
    chk("trip clear", 32'h0, 32'(comm_loss_trip_o));
    slow <= 1'b1;
    repeat (8) @(posedge mclk_i);
    chk("slow trip", 32'h1, 32'(comm_loss_trip_o));
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst_i = 1'b1;
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    {fault_active_i, motor_running_i, ext_fwd_i, ext_rev_i} = 4'h0;
    {lose, slow, ry} = '0;
    out_freq_i = 16'h1770;
    fault_hist_i = 16'h2A15;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_basic();
    t_param();
    t_freq();
    t_fault();
    t_mode();
    t_trip();
    end_sim();
  end
endmodule
